// ===== rtl/tstr_dev.sv
// Device end: serial slave with temperature conversion and tuning registers.
// Functional notes
// - Trigger bit starts measurement, always reads zero.
// - Running flag high for whole measurement.
// - Host avoids receiver while running flag set.
// - Result is 8 bits, minus one per degree.
// - Gain select 0x1B normal, 0x2D high sensitivity.
// - First trim 0x5D boost, 0x55 normal.
// - Host restores first trim 0x55 before receive.
// - Second trim 0x7C boost, 0x70 normal.
// - Fading margin 0x00 normal, 0x20/0x30 improved.
// - Correction equals offset times 488 Hz.
// - Host waits 10 ms after power-on reset.
// - Host leaves reset pin floating at power-on.
// - Manual reset drives pin high about 100 us.
// - Host waits 5 ms after manual reset.
// - Clock output toggling signals device ready.
`timescale 1ns/10ps
module tstr_dev #(
   parameter int CONV_CYCLES = tstr_pkg::CONV_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        srst,
   tstr_link_if.dev         link,
   input  wire logic [7:0]  temp_sense,
   input  wire logic        low_index_correction_enable,
   output logic [7:0]       rx_gain_select,
   output logic [7:0]       high_power_trim_a,
   output logic [7:0]       high_power_trim_b,
   output logic [7:0]       fading_margin_select,
   output logic [7:0]       low_index_freq_offset,
   output logic [16:0]      freq_correction_hz,
   output logic             high_sensitivity,
   output logic             boost_amp_enable,
   output logic             margin_improved,
   output logic             conv_in_progress,
   output logic             dev_ready
);
   typedef enum logic [1:0] {
      TSTR_CONV_IDLE = 2'b01,
      TSTR_CONV_RUN  = 2'b10
   } tstr_conv_e;

   logic [2:0]  sclk_s;
   logic [1:0]  cs_s;
   logic [1:0]  mosi_s;
   logic [1:0]  rstp_s;
   logic        dev_rst;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [4:0]  bit_cnt;
   logic [15:0] rx_shift;
   logic [7:0]  tx_shift;
   logic [7:0]  rd_value;
   logic        wr_stb;
   logic [6:0]  wr_addr;
   logic [7:0]  wr_data;
   tstr_conv_e  conv_state;
   logic [31:0] conv_cnt;
   logic [7:0]  temp_reading;
   logic [15:0] ready_cnt;
   logic [7:0]  tick_cnt;

   // Pins from the host pass two flip-flops before any use.
   always_ff @(posedge clk) begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s   <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      rstp_s <= {rstp_s[0], link.rst_pin};
   end

   assign sclk_rise = sclk_s[1] & ~sclk_s[2];
   assign sclk_fall = ~sclk_s[1] & sclk_s[2];

   // Either reset source returns the whole register set to its reset values.
   always_ff @(posedge clk) begin
      dev_rst <= srst | rstp_s[1];
   end

   // Frame: write flag, seven address bits, eight data bits, MSB first.
   always_ff @(posedge clk) begin
      if (dev_rst || cs_s[1]) begin
         bit_cnt  <= 5'h00;
         rx_shift <= 16'h0000;
      end else if (sclk_rise && bit_cnt < 5'(tstr_pkg::SPI_FRAME_BITS)) begin
         bit_cnt  <= bit_cnt + 5'h01;
         rx_shift <= {rx_shift[14:0], mosi_s[1]};
      end
   end

   always_comb begin
      case ({rx_shift[5:0], mosi_s[1]})
         tstr_pkg::ADDR_TEMP_CONTROL:   rd_value = {4'h0, 1'b0, conv_in_progress, tstr_pkg::TEMP_CTRL_LOW};
         tstr_pkg::ADDR_TEMP_RESULT:    rd_value = temp_reading;
         tstr_pkg::ADDR_LNA_SENS:       rd_value = rx_gain_select;
         tstr_pkg::ADDR_PA_TRIM_FIRST:  rd_value = high_power_trim_a;
         tstr_pkg::ADDR_PA_TRIM_SECOND: rd_value = high_power_trim_b;
         tstr_pkg::ADDR_GAIN_CONTROL:   rd_value = fading_margin_select;
         tstr_pkg::ADDR_FREQ_OFFSET:    rd_value = low_index_freq_offset;
         default:                       rd_value = 8'h00;
      endcase
   end

   // Read data leaves on falling edges so the host samples it on the next rising edge.
   always_ff @(posedge clk) begin
      if (dev_rst || cs_s[1]) begin
         tx_shift      <= 8'h00;
         link.miso_o   <= 1'b0;
         link.miso_oe_n <= 1'b1;
      end else begin
         link.miso_oe_n <= 1'b0;
         if (sclk_rise && bit_cnt == 5'h07) begin
            tx_shift <= rd_value;
         end else if (sclk_fall && bit_cnt >= 5'h08 && bit_cnt < 5'(tstr_pkg::SPI_FRAME_BITS)) begin
            link.miso_o <= tx_shift[7];
            tx_shift    <= {tx_shift[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      wr_stb  <= ~dev_rst & ~cs_s[1] & sclk_rise & (bit_cnt == 5'h0F) & rx_shift[14];
      wr_addr <= rx_shift[13:7];
      wr_data <= {rx_shift[6:0], mosi_s[1]};
   end

   always_ff @(posedge clk) begin
      if (dev_rst) begin
         rx_gain_select        <= tstr_pkg::RST_LNA_SENS;
         high_power_trim_a     <= tstr_pkg::RST_PA_TRIM_FIRST;
         high_power_trim_b     <= tstr_pkg::RST_PA_TRIM_SECOND;
         fading_margin_select  <= tstr_pkg::RST_GAIN_CONTROL;
         low_index_freq_offset <= tstr_pkg::RST_FREQ_OFFSET;
      end else if (wr_stb) begin
         case (wr_addr)
            tstr_pkg::ADDR_LNA_SENS:       rx_gain_select        <= wr_data;
            tstr_pkg::ADDR_PA_TRIM_FIRST:  high_power_trim_a     <= wr_data;
            tstr_pkg::ADDR_PA_TRIM_SECOND: high_power_trim_b     <= wr_data;
            tstr_pkg::ADDR_GAIN_CONTROL:   fading_margin_select  <= wr_data;
            tstr_pkg::ADDR_FREQ_OFFSET:    low_index_freq_offset <= wr_data;
            default: ;
         endcase
      end
   end

   // Decoded settings; any other gain or trim value leaves the analog path normal, while any nonzero margin select means improved.
   always_ff @(posedge clk) begin
      high_sensitivity   <= (rx_gain_select == tstr_pkg::LNA_HIGH_SENS);
      boost_amp_enable   <= (high_power_trim_a == tstr_pkg::PA_TRIM_FIRST_BOOST) &
                            (high_power_trim_b == tstr_pkg::PA_TRIM_SECOND_BOOST);
      margin_improved    <= (fading_margin_select != tstr_pkg::GAIN_NORMAL);
      freq_correction_hz <= low_index_correction_enable ?
                            17'(low_index_freq_offset * tstr_pkg::FREQ_STEP_HZ) : 17'h00000;
   end

   // A trigger during a running measurement is ignored rather than restarting it.
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         conv_state       <= TSTR_CONV_IDLE;
         conv_cnt         <= 32'h00000000;
         conv_in_progress <= 1'b0;
         temp_reading     <= 8'h00;
      end else begin
         case (conv_state)
            TSTR_CONV_IDLE: begin
               if (wr_stb && wr_addr == tstr_pkg::ADDR_TEMP_CONTROL && wr_data[tstr_pkg::CONV_TRIGGER_BIT]) begin
                  conv_state       <= TSTR_CONV_RUN;
                  conv_cnt         <= 32'h00000000;
                  conv_in_progress <= 1'b1;
               end
            end
            TSTR_CONV_RUN: begin
               if (conv_cnt == 32'(CONV_CYCLES - 1)) begin
                  conv_state       <= TSTR_CONV_IDLE;
                  conv_in_progress <= 1'b0;
                  temp_reading     <= temp_sense;
               end else begin
                  conv_cnt <= conv_cnt + 32'h00000001;
               end
            end
            default: begin
               conv_state       <= TSTR_CONV_IDLE;
               conv_in_progress <= 1'b0;
            end
         endcase
      end
   end

   // The clock output stays quiet until the device has settled after reset.
   always_ff @(posedge clk) begin
      if (dev_rst) begin
         ready_cnt             <= 16'h0000;
         tick_cnt              <= 8'h00;
         dev_ready             <= 1'b0;
         link.clock_output_pin <= 1'b0;
      end else if (!dev_ready) begin
         ready_cnt <= ready_cnt + 16'h0001;
         if (ready_cnt == 16'(tstr_pkg::READY_CYCLES - 1)) begin
            dev_ready <= 1'b1;
         end
      end else if (tick_cnt == 8'(tstr_pkg::CLK_PIN_HALF - 1)) begin
         tick_cnt              <= 8'h00;
         link.clock_output_pin <= ~link.clock_output_pin;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end
endmodule : tstr_dev

// ===== rtl/tstr_pkg.sv
// Shared constants of the temperature and tuning register block and its host.
package tstr_pkg;
   // Clock and timing.
   localparam int CLK_PERIOD_NS      = 8;
   localparam int TEMP_CONV_NS       = 100000;
   localparam int CONV_CYCLES        = (TEMP_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_WAIT_MS        = 10;
   localparam int POR_WAIT_CYCLES    = (POR_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAN_HOLD_US        = 100;
   localparam int MAN_HOLD_CYCLES    = (MAN_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAN_WAIT_MS        = 5;
   localparam int MAN_WAIT_CYCLES    = (MAN_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_CYCLES       = 64;
   localparam int CLK_PIN_HALF       = 4;
   localparam int SCLK_HALF          = 8;
   localparam int FREQ_STEP_HZ       = 488;
   // Register offsets.
   localparam logic [6:0] ADDR_TEMP_CONTROL   = 7'h4E;
   localparam logic [6:0] ADDR_TEMP_RESULT    = 7'h4F;
   localparam logic [6:0] ADDR_LNA_SENS       = 7'h58;
   localparam logic [6:0] ADDR_PA_TRIM_FIRST  = 7'h5A;
   localparam logic [6:0] ADDR_PA_TRIM_SECOND = 7'h5C;
   localparam logic [6:0] ADDR_GAIN_CONTROL   = 7'h6F;
   localparam logic [6:0] ADDR_FREQ_OFFSET    = 7'h71;
   // Field positions and fixed values.
   localparam int          CONV_TRIGGER_BIT  = 3;
   localparam int          CONV_RUNNING_BIT  = 2;
   localparam logic [1:0]  TEMP_CTRL_LOW     = 2'h1;
   localparam int          SPI_WNR_BIT       = 15;
   localparam int          SPI_FRAME_BITS    = 16;
   // Reset values and documented settings.
   localparam logic [7:0] RST_LNA_SENS       = 8'h1B;
   localparam logic [7:0] LNA_HIGH_SENS      = 8'h2D;
   localparam logic [7:0] RST_PA_TRIM_FIRST  = 8'h55;
   localparam logic [7:0] PA_TRIM_FIRST_BOOST = 8'h5D;
   localparam logic [7:0] RST_PA_TRIM_SECOND = 8'h70;
   localparam logic [7:0] PA_TRIM_SECOND_BOOST = 8'h7C;
   localparam logic [7:0] RST_GAIN_CONTROL   = 8'h30;
   localparam logic [7:0] GAIN_NORMAL        = 8'h00;
   localparam logic [7:0] GAIN_MARGIN_CORR_ON = 8'h20;
   localparam logic [7:0] RST_FREQ_OFFSET    = 8'h00;
endpackage : tstr_pkg

// ===== rtl/tstr_link_if.sv
// Serial link between the register block and its host, with the reset and clock output pins.
`timescale 1ns/10ps
interface tstr_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_o;
   logic miso_oe_n;
   logic miso;
   logic rst_o;
   logic rst_oe_n;
   logic rst_pin;
   logic clock_output_pin;

   // Undriven lines settle low, as a pull-down would leave them.
   assign miso    = miso_oe_n ? 1'b0 : miso_o;
   assign rst_pin = rst_oe_n ? 1'b0 : rst_o;

   modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe_n,
                input rst_pin, output clock_output_pin);
   modport host (output sclk, output cs_n, output mosi, input miso,
                 output rst_o, output rst_oe_n, input clock_output_pin);
endinterface : tstr_link_if

// ===== rtl/tstr_host.sv
// Host end: reset sequencing, readiness detection and serial register access.
`timescale 1ns/10ps
module tstr_host #(
   parameter int POR_WAIT_CYCLES = tstr_pkg::POR_WAIT_CYCLES,
   parameter int MAN_HOLD_CYCLES = tstr_pkg::MAN_HOLD_CYCLES,
   parameter int MAN_WAIT_CYCLES = tstr_pkg::MAN_WAIT_CYCLES,
   parameter logic [7:0] CAL_OFFSET = 8'h00
) (
   input  wire logic        clk,
   input  wire logic        srst,
   tstr_link_if.host        link,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [6:0]  cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic        man_reset_req,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_rdata,
   output logic             dev_ready,
   output logic             rx_permit,
   output logic [7:0]       temp_celsius
);
   typedef enum logic [3:0] {
      TSTR_H_HOLD = 4'b0001,
      TSTR_H_WAIT = 4'b0010,
      TSTR_H_IDLE = 4'b0100,
      TSTR_H_XFER = 4'b1000
   } tstr_host_e;

   tstr_host_e  state;
   logic [31:0] wait_cnt;
   logic [31:0] wait_lim;
   logic [2:0]  clko_s;
   logic [1:0]  miso_s;
   logic [7:0]  div_cnt;
   logic [4:0]  bit_cnt;
   logic [15:0] tx_shift;
   logic [7:0]  rx_byte;
   logic        cur_write;
   logic [6:0]  cur_addr;
   logic [7:0]  cur_wdata;
   logic        conv_seen;
   logic [7:0]  trim_a;
   logic [7:0]  trim_b;

   always_ff @(posedge clk) begin
      clko_s <= {clko_s[1:0], link.clock_output_pin};
      miso_s <= {miso_s[0], link.miso};
   end

   // Any clock output edge ends the hold-off early.
   always_ff @(posedge clk) begin
      if (srst) begin
         state         <= TSTR_H_WAIT;
         wait_cnt      <= 32'h00000000;
         wait_lim      <= 32'(POR_WAIT_CYCLES);
         link.rst_o    <= 1'b0;
         link.rst_oe_n <= 1'b1;
         dev_ready     <= 1'b0;
         cmd_ready     <= 1'b0;
      end else begin
         case (state)
            TSTR_H_HOLD: begin
               link.rst_o    <= 1'b1;
               link.rst_oe_n <= 1'b0;
               wait_cnt      <= wait_cnt + 32'h00000001;
               if (wait_cnt == 32'(MAN_HOLD_CYCLES)) begin
                  link.rst_oe_n <= 1'b1;
                  link.rst_o    <= 1'b0;
                  wait_cnt      <= 32'h00000000;
                  wait_lim      <= 32'(MAN_WAIT_CYCLES);
                  state         <= TSTR_H_WAIT;
               end
            end
            TSTR_H_WAIT: begin
               wait_cnt <= wait_cnt + 32'h00000001;
               if (clko_s[1] != clko_s[2] || wait_cnt == wait_lim - 32'h00000001) begin
                  state     <= TSTR_H_IDLE;
                  dev_ready <= 1'b1;
                  cmd_ready <= 1'b1;
               end
            end
            TSTR_H_IDLE: begin
               if (man_reset_req) begin
                  state     <= TSTR_H_HOLD;
                  wait_cnt  <= 32'h00000000;
                  dev_ready <= 1'b0;
                  cmd_ready <= 1'b0;
               end else if (cmd_valid) begin
                  state     <= TSTR_H_XFER;
                  cmd_ready <= 1'b0;
               end
            end
            TSTR_H_XFER: begin
               if (bit_cnt == 5'(tstr_pkg::SPI_FRAME_BITS) && div_cnt == 8'(tstr_pkg::SCLK_HALF - 1)
                   && !link.sclk) begin
                  state     <= TSTR_H_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            default: state <= TSTR_H_WAIT;
         endcase
      end
   end

   // Serial frame: data changes on falling edges, miso is sampled on rising edges.
   always_ff @(posedge clk) begin
      if (srst || state != TSTR_H_XFER) begin
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         div_cnt   <= 8'h00;
         bit_cnt   <= 5'h00;
         rx_byte   <= 8'h00;
         rsp_valid <= 1'b0;
         tx_shift  <= {cmd_write, cmd_addr, cmd_wdata};
         link.mosi <= cmd_write;
         cur_write <= cmd_write;
         cur_addr  <= cmd_addr;
         cur_wdata <= cmd_wdata;
      end else begin
         link.cs_n <= 1'b0;
         rsp_valid <= 1'b0;
         if (div_cnt != 8'(tstr_pkg::SCLK_HALF - 1)) begin
            div_cnt <= div_cnt + 8'h01;
         end else if (bit_cnt == 5'(tstr_pkg::SPI_FRAME_BITS) && !link.sclk) begin
            rsp_valid <= 1'b1;
            link.cs_n <= 1'b1;
         end else begin
            div_cnt   <= 8'h00;
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
               bit_cnt <= bit_cnt + 5'h01;
               rx_byte <= {rx_byte[6:0], miso_s[1]};
            end else begin
               tx_shift  <= {tx_shift[14:0], 1'b0};
               link.mosi <= tx_shift[14];
            end
         end
      end
   end

   // Receiver use is refused while a measurement runs or a trim is left boosted.
   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_rdata    <= 8'h00;
         conv_seen    <= 1'b0;
         trim_a       <= tstr_pkg::RST_PA_TRIM_FIRST;
         trim_b       <= tstr_pkg::RST_PA_TRIM_SECOND;
         temp_celsius <= 8'h00;
         rx_permit    <= 1'b0;
      end else begin
         rx_permit <= dev_ready & ~conv_seen & (trim_a == tstr_pkg::RST_PA_TRIM_FIRST)
                      & (trim_b == tstr_pkg::RST_PA_TRIM_SECOND);
         if (rsp_valid) begin
            rsp_rdata <= rx_byte;
            if (cur_write && cur_addr == tstr_pkg::ADDR_PA_TRIM_FIRST) begin
               trim_a <= cur_wdata;
            end
            if (cur_write && cur_addr == tstr_pkg::ADDR_PA_TRIM_SECOND) begin
               trim_b <= cur_wdata;
            end
            if (cur_write && cur_addr == tstr_pkg::ADDR_TEMP_CONTROL) begin
               conv_seen <= cur_wdata[tstr_pkg::CONV_TRIGGER_BIT] | conv_seen;
            end
            if (!cur_write && cur_addr == tstr_pkg::ADDR_TEMP_CONTROL) begin
               conv_seen <= rx_byte[tstr_pkg::CONV_RUNNING_BIT];
            end
            if (!cur_write && cur_addr == tstr_pkg::ADDR_TEMP_RESULT) begin
               temp_celsius <= CAL_OFFSET - rx_byte;
            end
         end
      end
   end
endmodule : tstr_host

// ===== sim/tstr_asserts.sv
// Concurrent checks on the link between the register block and its host, and on the block's conversion flag and decoded settings.
`timescale 1ns/10ps
module tstr_asserts #(
   parameter int CONV_CYCLES     = 600,
   parameter int MAN_HOLD_CYCLES = 50
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        rst_pin,
   input wire logic        rst_oe_n,
   input wire logic        clock_output_pin,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic        rsp_valid,
   input wire logic        conv_in_progress,
   input wire logic        dev_ready,
   input wire logic [7:0]  rx_gain_select,
   input wire logic        high_sensitivity,
   input wire logic [7:0]  high_power_trim_a,
   input wire logic [7:0]  high_power_trim_b,
   input wire logic        boost_amp_enable,
   input wire logic [7:0]  fading_margin_select,
   input wire logic        margin_improved,
   input wire logic [7:0]  low_index_freq_offset,
   input wire logic        low_index_correction_enable,
   input wire logic [16:0] freq_correction_hz
);
   int         ccnt;
   int         hcnt;
   logic [4:0] scnt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // Counters stand in for long repetitions, which the tools cannot unroll cheaply.
   always_ff @(posedge clk) begin
      ccnt <= conv_in_progress ? ccnt + 1 : 0;
   end
   always_ff @(posedge clk) begin
      hcnt <= rst_pin ? hcnt + 1 : 0;
   end
   always_ff @(posedge clk) begin
      if (cs_n) begin
         scnt <= 5'h00;
      end else if ($rose(sclk)) begin
         scnt <= scnt + 5'h01;
      end
   end
   a_frame_rises: assert property ($rose(cs_n) |-> scnt == 5'h10)
      else $error("Frame did not carry sixteen clock rises.");
   a_cmd_start: assert property (cmd_ready && cmd_valid |=> !cmd_ready ##1 !cs_n)
      else $error("Accepted command did not open a frame.");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("Response strobe lasted more than one cycle.");
   a_conv_length: assert property ($fell(conv_in_progress) |-> ccnt == CONV_CYCLES)
      else $error("Conversion flag length is wrong.");
   a_man_hold: assert property ($fell(rst_pin) |-> hcnt == MAN_HOLD_CYCLES)
      else $error("Manual reset pulse length is wrong.");
   a_ready_quiet: assert property ($fell(srst) |-> (!clock_output_pin && !dev_ready) [*8])
      else $error("Clock output active right after reset.");
   a_por_float: assert property ($fell(srst) |-> (cs_n && rst_oe_n) [*8])
      else $error("Host touched the link during power-on wait.");
   a_high_sens: assert property (!$past(srst) |-> high_sensitivity == ($past(rx_gain_select) == 8'h2D))
      else $error("Sensitivity mode does not follow its register.");
   a_boost_both: assert property (!$past(srst) |->
      boost_amp_enable == ($past(high_power_trim_a) == 8'h5D && $past(high_power_trim_b) == 8'h7C))
      else $error("Boost mode does not follow the trims.");
   a_margin_sel: assert property (!$past(srst) |-> margin_improved == ($past(fading_margin_select) != 8'h00))
      else $error("Margin mode does not follow its register.");
   a_freq_step: assert property (!$past(srst) |-> freq_correction_hz == ($past(low_index_correction_enable) ?
      17'($past(low_index_freq_offset)) * 17'h001E8 : 17'h00000))
      else $error("Frequency correction is not offset times step.");
endmodule : tstr_asserts

// ===== sim/testbench.sv
// Self-checking bench joining the register block and its host across the serial link.
`timescale 1ns/10ps
module testbench;
   logic        clk, srst, cmd_valid, cmd_write, man_reset_req, enable;
   logic [6:0]  cmd_addr;
   logic [7:0]  cmd_wdata, temp_sense, rsp_rdata, temp_celsius, mon_miso, r;
   logic [7:0]  rx_gain_select, high_power_trim_a, high_power_trim_b, fading_margin_select, low_index_freq_offset;
   logic [16:0] freq_correction_hz;
   logic        high_sensitivity, boost_amp_enable, margin_improved, conv_in_progress, dev_ready_d;
   logic        cmd_ready, rsp_valid, dev_ready_h, rx_permit;
   logic [15:0] mon_word;
   int          fails, checks, n;
   tstr_link_if i_tstr_link_if ();
   tstr_dev #(.CONV_CYCLES(600)) i_tstr_dev (.clk(clk), .srst(srst), .link(i_tstr_link_if), .temp_sense(temp_sense),
      .low_index_correction_enable(enable), .rx_gain_select(rx_gain_select), .high_power_trim_a(high_power_trim_a),
      .high_power_trim_b(high_power_trim_b), .fading_margin_select(fading_margin_select),
      .low_index_freq_offset(low_index_freq_offset), .freq_correction_hz(freq_correction_hz),
      .high_sensitivity(high_sensitivity), .boost_amp_enable(boost_amp_enable), .margin_improved(margin_improved),
      .conv_in_progress(conv_in_progress), .dev_ready(dev_ready_d));
   tstr_host #(.POR_WAIT_CYCLES(300), .MAN_HOLD_CYCLES(50), .MAN_WAIT_CYCLES(300)) i_tstr_host (
      .clk(clk), .srst(srst), .link(i_tstr_link_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .man_reset_req(man_reset_req), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_ready(dev_ready_h), .rx_permit(rx_permit),
      .temp_celsius(temp_celsius));
   tstr_asserts i_tstr_asserts (.clk(clk), .srst(srst),
      .sclk(i_tstr_link_if.sclk), .cs_n(i_tstr_link_if.cs_n), .rst_pin(i_tstr_link_if.rst_pin),
      .rst_oe_n(i_tstr_link_if.rst_oe_n), .clock_output_pin(i_tstr_link_if.clock_output_pin),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .conv_in_progress(conv_in_progress),
      .dev_ready(dev_ready_d), .rx_gain_select(rx_gain_select), .high_sensitivity(high_sensitivity),
      .high_power_trim_a(high_power_trim_a), .high_power_trim_b(high_power_trim_b),
      .boost_amp_enable(boost_amp_enable), .fading_margin_select(fading_margin_select),
      .margin_improved(margin_improved), .low_index_freq_offset(low_index_freq_offset),
      .low_index_correction_enable(enable), .freq_correction_hz(freq_correction_hz));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // The monitor samples the link on rising serial clock.
   always @(negedge i_tstr_link_if.cs_n) begin
      mon_word = 16'h0000;
      mon_miso = 8'h00;
   end
   always @(posedge i_tstr_link_if.sclk) begin
      mon_word = {mon_word[14:0], i_tstr_link_if.mosi};
      mon_miso = {mon_miso[6:0], i_tstr_link_if.miso};
   end
   task automatic stop_test();
      if (fails == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_on(input logic [1:0] sel, input logic lvl, input int lim);
      n = 0;
      while ((sel == 2'h0 ? cmd_ready : sel == 2'h1 ? rsp_valid : conv_in_progress) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(17'(n < lim), 17'h00001);
   endtask : wait_on
   task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] rd);
      wait_on(2'h0, 1'b1, 2000);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = addr;
      cmd_wdata = data;
      @(negedge clk);
      cmd_valid = 1'b0;
      wait_on(2'h1, 1'b1, 2000);
      @(negedge clk);
      rd = rsp_rdata;
      chk(17'(mon_word[15:8]), 17'({wr, addr}));
      chk(17'(mon_word[7:0]), 17'(data));
   endtask : xfer
   task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
      xfer(1'b0, addr, 8'h00, r);
      chk(17'({r, mon_miso}), 17'({exp, exp}));
   endtask : rd_chk
   task automatic wr_rd(input logic [6:0] addr, input logic [7:0] data);
      xfer(1'b1, addr, data, r);
      rd_chk(addr, data);
   endtask : wr_rd
   task automatic t_defaults();
      rd_chk(tstr_pkg::ADDR_TEMP_CONTROL, 8'h01);
      rd_chk(tstr_pkg::ADDR_TEMP_RESULT, 8'h00);
      rd_chk(tstr_pkg::ADDR_LNA_SENS, 8'h1B);
      rd_chk(tstr_pkg::ADDR_PA_TRIM_FIRST, 8'h55);
      rd_chk(tstr_pkg::ADDR_PA_TRIM_SECOND, 8'h70);
      rd_chk(tstr_pkg::ADDR_GAIN_CONTROL, 8'h30);
      rd_chk(tstr_pkg::ADDR_FREQ_OFFSET, 8'h00);
      xfer(1'b1, 7'h10, 8'hFF, r);
      rd_chk(7'h10, 8'h00);
      xfer(1'b1, tstr_pkg::ADDR_TEMP_RESULT, 8'hA5, r);
      rd_chk(tstr_pkg::ADDR_TEMP_RESULT, 8'h00);
      chk(17'(rx_permit), 17'h00001);
   endtask : t_defaults
   task automatic t_tuning();
      logic [7:0] gv [3];
      gv = '{8'h00, 8'h20, 8'h30};
      wr_rd(tstr_pkg::ADDR_LNA_SENS, 8'h2D);
      chk(17'(high_sensitivity), 17'h00001);
      wr_rd(tstr_pkg::ADDR_LNA_SENS, 8'h1B);
      chk(17'(high_sensitivity), 17'h00000);
      wr_rd(tstr_pkg::ADDR_PA_TRIM_FIRST, 8'h5D);
      chk(17'({boost_amp_enable, rx_permit}), 17'h00000);
      wr_rd(tstr_pkg::ADDR_PA_TRIM_SECOND, 8'h7C);
      chk(17'({boost_amp_enable, rx_permit}), 17'h00002);
      wr_rd(tstr_pkg::ADDR_PA_TRIM_FIRST, 8'h55);
      chk(17'({boost_amp_enable, rx_permit}), 17'h00000);
      wr_rd(tstr_pkg::ADDR_PA_TRIM_SECOND, 8'h70);
      chk(17'({boost_amp_enable, rx_permit}), 17'h00001);
      for (int i = 0; i < 3; i++) begin
         wr_rd(tstr_pkg::ADDR_GAIN_CONTROL, gv[i]);
         chk(17'(margin_improved), 17'(i != 0));
      end
      enable = 1'b1;
      wr_rd(tstr_pkg::ADDR_FREQ_OFFSET, 8'h01);
      chk(freq_correction_hz, 17'h001E8);
      wr_rd(tstr_pkg::ADDR_FREQ_OFFSET, 8'hFF);
      chk(freq_correction_hz, 17'h1E618);
      enable = 1'b0;
      repeat (3) @(negedge clk);
      chk(freq_correction_hz, 17'h00000);
   endtask : t_tuning
   task automatic t_temp();
      temp_sense = 8'h3A;
      xfer(1'b1, tstr_pkg::ADDR_TEMP_CONTROL, 8'h08, r);
      chk(17'(conv_in_progress), 17'h00001);
      rd_chk(tstr_pkg::ADDR_TEMP_CONTROL, 8'h05);
      chk(17'(rx_permit), 17'h00000);
      wait_on(2'h2, 1'b0, 1000);
      rd_chk(tstr_pkg::ADDR_TEMP_RESULT, 8'h3A);
      rd_chk(tstr_pkg::ADDR_TEMP_CONTROL, 8'h01);
      @(negedge clk);
      chk(17'(temp_celsius), 17'h000C6);
      chk(17'(rx_permit), 17'h00001);
   endtask : t_temp
   task automatic t_man_reset();
      wr_rd(tstr_pkg::ADDR_PA_TRIM_FIRST, 8'h5D);
      wr_rd(tstr_pkg::ADDR_FREQ_OFFSET, 8'h44);
      man_reset_req = 1'b1;
      wait_on(2'h0, 1'b0, 20);
      man_reset_req = 1'b0;
      rd_chk(tstr_pkg::ADDR_PA_TRIM_FIRST, 8'h55);
      rd_chk(tstr_pkg::ADDR_FREQ_OFFSET, 8'h00);
      chk(17'({dev_ready_h, dev_ready_d}), 17'h00003);
   endtask : t_man_reset
   initial begin
      fails = 0;
      checks = 0;
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 7'h00;
      cmd_wdata = 8'h00;
      man_reset_req = 1'b0;
      enable = 1'b0;
      temp_sense = 8'h00;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      wait_on(2'h0, 1'b1, 2000);
      chk(17'({dev_ready_h, dev_ready_d}), 17'h00003);
      t_defaults();
      t_tuning();
      t_temp();
      t_man_reset();
      stop_test();
   end
   // The limit allows about two and a half times the expected run.
   initial begin
      #(30000 * 8);
      fails++;
      stop_test();
   end
endmodule : testbench
